// ### design/envelope_token_bucket_meter.sv
`include "meter_defs.svh"
module envelope_token_bucket_meter
   import meter_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 reset_n,
   input  wire logic [`ADDR_W-1:0]   reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   input  wire rx_s                  rx,
   output verdict_s                  verdict
);
   localparam int NF = 3;
   function automatic logic [31:0] min32(input logic [31:0] a,
                                         input logic [31:0] b);
      min32 = (a < b) ? a : b;
   endfunction : min32
   function automatic logic [31:0] sadd(input logic [31:0] a,
                                        input logic [31:0] b);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, b};
      sadd = s[32] ? 32'hffffffff : s[31:0];
   endfunction : sadd
   // ****************************************************
   // Configuration registers
   // ****************************************************
   logic [31:0] crate_q [NF];
   logic [31:0] erate_q [NF];
   logic [31:0] ccap_q  [NF];
   logic [31:0] ecap_q  [NF];
   logic [31:0] cbs_q   [NF];
   logic [31:0] ebs_q   [NF];
   logic        cf_q    [NF];
   logic [31:0] ccnt_q  [NF];
   logic [31:0] ecnt_q  [NF];
   logic [31:0] ccnt_d  [NF];
   logic [31:0] ecnt_d  [NF];
   logic [15:0] interval_q;
   logic        envtype_q;
   logic        gap_err_q;
   logic [31:0] mbits_q;
   logic [31:0] mtime_q;
   logic [31:0] rdata_q;
   // Field decode of the register port
   wire  [1:0]  a_flow  = reg_addr[5:4];
   wire  [3:0]  a_fld   = reg_addr[3:0];
   wire         a_glb   = (a_flow == `GLB_BASE);
   wire         wr_glb  = reg_wr && a_glb;
   wire         clr_st  = wr_glb && (a_fld == `GLB_STATUS);
   wire         clr_me  = wr_glb && (a_fld == `GLB_MBITS);
   // Per-flow settings; a write to an unmapped field is ignored
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NF; i++) begin
         if (!reset_n) begin
            crate_q[i] <= 32'h0;
            erate_q[i] <= 32'h0;
            ccap_q[i]  <= 32'h0;
            ecap_q[i]  <= 32'h0;
            cbs_q[i]   <= 32'h0;
            ebs_q[i]   <= 32'h0;
            cf_q[i]    <= 1'b0;
         end else if (reg_wr && !a_glb && a_flow == 2'(i)) begin
            case (a_fld)
               `FLD_CRATE: crate_q[i] <= reg_wdata;
               `FLD_ERATE: erate_q[i] <= reg_wdata;
               `FLD_CCAP:  ccap_q[i]  <= reg_wdata;
               `FLD_ECAP:  ecap_q[i]  <= reg_wdata;
               `FLD_CBS:   cbs_q[i]   <= reg_wdata;
               `FLD_EBS:   ebs_q[i]   <= reg_wdata;
               `FLD_CF:    cf_q[i]    <= reg_wdata[0];
               default:    ;
            endcase
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         interval_q <= `INTERVAL_RST;
         envtype_q  <= 1'b0;
      end else if (wr_glb && a_fld == `GLB_INTERVAL) begin
         interval_q <= reg_wdata[15:0];
      end else if (wr_glb && a_fld == `GLB_ENVTYPE) begin
         envtype_q  <= reg_wdata[0];
      end
   end
   // ****************************************************
   // Refill interval divider
   // ****************************************************
   logic [15:0] div_q;
   wire         tick = (div_q == 16'h0);
   always_ff @(posedge clk_sys) begin
      if (!reset_n || tick) begin
         div_q <= interval_q;
      end else begin
         div_q <= div_q - 16'h1;
      end
   end
   // ****************************************************
   // Token cascade, highest rank (flow 2) down to flow 0
   // ****************************************************
   logic [31:0] c_in [NF], c_add [NF], c_put [NF], c_ovf [NF];
   logic [31:0] e_in [NF], e_add [NF], e_put [NF], e_ovf [NF];
   logic [31:0] e_xtra [NF];
   logic [31:0] c_ref [NF], e_ref [NF];
   always_comb begin
      logic [31:0] c_pass;
      logic [31:0] e_pass;
      c_pass = 32'h0;
      e_pass = 32'h0;
      for (int i = NF - 1; i >= 0; i--) begin
         c_in[i]  = tick ? sadd(crate_q[i], c_pass) : 32'h0;
         c_add[i] = min32(c_in[i], ccap_q[i]);
         c_put[i] = min32(c_add[i], (ccnt_q[i] < cbs_q[i]) ?
                          cbs_q[i] - ccnt_q[i] : 32'h0);
         c_ovf[i] = c_in[i] - c_put[i];
         e_xtra[i] = cf_q[i] ? c_ovf[i] : 32'h0;
         c_pass    = cf_q[i] ? 32'h0 : c_ovf[i];
         e_in[i]  = tick ? sadd(sadd(erate_q[i], e_xtra[i]), e_pass)
                         : 32'h0;
         e_add[i] = min32(e_in[i], ecap_q[i]);
         e_put[i] = min32(e_add[i], (ecnt_q[i] < ebs_q[i]) ?
                          ebs_q[i] - ecnt_q[i] : 32'h0);
         e_ovf[i] = e_in[i] - e_put[i];
         e_pass   = e_ovf[i];
         c_ref[i] = ccnt_q[i] + c_put[i];
         e_ref[i] = ecnt_q[i] + e_put[i];
      end
      // What leaves flow 0 is dropped here
   end

   // ****************************************************
   // Frame length and gap tracking on the link
   // ****************************************************
   logic [15:0] len_q;
   logic        in_frame_q;
   logic [7:0]  gap_q;
   logic        seen_q;
   wire         sof   = rx.valid && !in_frame_q;
   wire         eof   = rx.valid && rx.last;
   wire  [31:0] flen  = {16'h0, len_q + 16'h1};  // Extension never added
   wire         short = sof && seen_q && (gap_q < 8'(`GAP_CYCLES));
   // Bytes counted only while the link presents header..FCS
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         len_q      <= 16'h0;
         in_frame_q <= 1'b0;
      end else if (eof) begin
         len_q      <= 16'h0;
         in_frame_q <= 1'b0;
      end else if (rx.valid) begin
         len_q      <= len_q + 16'h1;
         in_frame_q <= 1'b1;
      end
   end
   // Idle slots since the last FCS byte; saturates to stay cheap
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         gap_q  <= 8'h0;
         seen_q <= 1'b0;
      end else if (eof) begin
         gap_q  <= 8'h0;
         seen_q <= 1'b1;
      end else if (!rx.valid && gap_q != 8'hff) begin
         gap_q  <= gap_q + 8'h1;
      end
   end
   // New error wins over a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         gap_err_q <= 1'b0;
      end else if (short) begin
         gap_err_q <= 1'b1;
      end else if (clr_st) begin
         gap_err_q <= 1'b0;
      end
   end
   // ****************************************************
   // Information rate measurement
   // ****************************************************
   logic        mrun_q;
   logic [31:0] last_t_q;
   logic [31:0] span_q;
   // Span in link bits from first bit; the overhead is added on read
   always_ff @(posedge clk_sys) begin
      if (!reset_n || clr_me) begin
         mrun_q   <= 1'b0;
         mbits_q  <= 32'h0;
         span_q   <= 32'h0;
         last_t_q <= 32'h0;
      end else begin
         if (sof || mrun_q) begin
            mrun_q <= 1'b1;
            span_q <= span_q + 32'(`BITS_PER_CYCLE);
         end
         if (eof) begin
            mbits_q  <= mbits_q + {flen[28:0], 3'b000};
            last_t_q <= span_q + 32'(`BITS_PER_CYCLE);
         end
      end
   end
   assign mtime_q = last_t_q + 32'(`OVH_BITS);

   // ****************************************************
   // Colour decision and deduction
   // ****************************************************
   wire  [1:0]  ff      = rx.flow;
   wire         metered = eof && (rx.ftype == envtype_q) &&
                          (ff < 2'(NF));
   wire         fit_c   = metered && (flen <= c_ref[ff]);
   wire         fit_e   = metered && !fit_c && (flen <= e_ref[ff]);
   always_comb begin
      for (int i = 0; i < NF; i++) begin
         ccnt_d[i] = c_ref[i];
         ecnt_d[i] = e_ref[i];
         if (fit_c && ff == 2'(i)) begin
            ccnt_d[i] = c_ref[i] - flen;
         end
         if (fit_e && ff == 2'(i)) begin
            ecnt_d[i] = e_ref[i] - flen;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NF; i++) begin
         if (!reset_n) begin
            ccnt_q[i] <= 32'h0;
            ecnt_q[i] <= 32'h0;
         end else begin
            ccnt_q[i] <= ccnt_d[i];
            ecnt_q[i] <= ecnt_d[i];
         end
      end
   end
   // Verdict for each frame end, one cycle after its last byte
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         verdict <= '0;
      end else begin
         verdict.valid  <= eof;
         verdict.flow   <= ff;
         verdict.colour <= fit_c ? COL_GREEN :
                           fit_e ? COL_YELLOW : COL_RED;
      end
   end

   // ****************************************************
   // Register read port, data one cycle after the strobe
   // ****************************************************
   logic [31:0] rd_mux;
   wire  [1:0]  rf = (a_flow < 2'(NF)) ? a_flow : 2'h0;
   always_comb begin
      rd_mux = 32'h0;
      if (a_glb) begin
         case (a_fld)
            `GLB_INTERVAL: rd_mux = {16'h0, interval_q};
            `GLB_ENVTYPE:  rd_mux = {31'h0, envtype_q};
            `GLB_MBITS:    rd_mux = mbits_q;
            `GLB_MTIME:    rd_mux = mtime_q;
            `GLB_STATUS:   rd_mux = {31'h0, gap_err_q};
            default:       rd_mux = 32'h0;
         endcase
      end else begin
         case (a_fld)
            `FLD_CRATE:  rd_mux = crate_q[rf];
            `FLD_ERATE:  rd_mux = erate_q[rf];
            `FLD_CCAP:   rd_mux = ccap_q[rf];
            `FLD_ECAP:   rd_mux = ecap_q[rf];
            `FLD_CBS:    rd_mux = cbs_q[rf];
            `FLD_EBS:    rd_mux = ebs_q[rf];
            `FLD_CF:     rd_mux = {31'h0, cf_q[rf]};
            `FLD_CCOUNT: rd_mux = ccnt_q[rf];
            `FLD_ECOUNT: rd_mux = ecnt_q[rf];
            default:     rd_mux = 32'h0;
         endcase
      end
   end
   // Read data holds only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !reg_rd) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= rd_mux;
      end
   end
   assign reg_rdata = rdata_q;
   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence s_frame_end;
      rx.valid && rx.last;
   endsequence
   a_verdict_pulse: assert property (s_frame_end |=> verdict.valid)
      else $error("verdict missing after frame end");
   a_gap_flag: assert property (short |=> gap_err_q)
      else $error("short gap not flagged");
   a_red_keeps: assert property (eof && !fit_c && !fit_e |=>
                  verdict.colour == COL_RED)
      else $error("uncovered frame not red");
   // Top flow uncoupled: only its own excess rate may reach its excess
   a_cf_separate: assert property (!cf_q[2] && tick |->
                  e_in[2] == erate_q[2])
      else $error("committed tokens leaked to excess");
   a_cf_route: assert property (cf_q[2] |-> e_xtra[2] == c_ovf[2])
      else $error("coupled overflow not routed");
   a_cap_fill: assert property (c_put[0] <= ccap_q[0] &&
                  e_put[0] <= ecap_q[0])
      else $error("fill exceeds cap");
   a_full_bucket: assert property (ccnt_q[2] >= cbs_q[2] |->
                  c_put[2] == 32'h0)
      else $error("full bucket took tokens");
   a_green_deduct: assert property (fit_c && ff == 2'h0 |=>
                  ccnt_q[0] == $past(c_ref[0]) - $past(flen))
      else $error("green deduction wrong");
   a_meter_type: assert property (eof && rx.ftype != envtype_q |=>
                  verdict.colour == COL_RED)
      else $error("foreign flow type metered");
endmodule : envelope_token_bucket_meter

// ### design/meter_defs.svh
`ifndef METER_DEFS_SVH
`define METER_DEFS_SVH
// Word addresses of the register port, flow registers at {flow, field}
`define ADDR_W          6
`define FLD_CRATE       4'h0
`define FLD_ERATE       4'h1
`define FLD_CCAP        4'h2
`define FLD_ECAP        4'h3
`define FLD_CBS         4'h4
`define FLD_EBS         4'h5
`define FLD_CF          4'h6
`define FLD_CCOUNT      4'h7
`define FLD_ECOUNT      4'h8
`define GLB_BASE        2'h3
`define GLB_INTERVAL    4'h0
`define GLB_ENVTYPE     4'h1
`define GLB_MBITS       4'h2
`define GLB_MTIME       4'h3
`define GLB_STATUS      4'h4
// Reset values and link timing
`define INTERVAL_RST    16'h007d
`define IPG_BITS        96
`define PKT_GAP_BYTES   20
`define OVH_BITS        160
`define LINK_MBPS       1000
`define CLK_MHZ         125
`define BYTE_BITS       8
`define GAP_CYCLES      ((`PKT_GAP_BYTES*`BYTE_BITS*`CLK_MHZ+`LINK_MBPS-1)/`LINK_MBPS)
`define BITS_PER_CYCLE  (`LINK_MBPS/`CLK_MHZ)
`endif

// ### design/meter_pkg.sv
package meter_pkg;
   typedef enum logic [1:0] {
      COL_GREEN  = 2'b00,
      COL_YELLOW = 2'b01,
      COL_RED    = 2'b10
   } colour_e;
   // One byte slot of the subscriber link, MAC header through FCS only
   typedef struct packed {
      logic       valid;
      logic       last;
      logic [1:0] flow;
      logic       ftype;
   } rx_s;
   typedef struct packed {
      logic       valid;
      colour_e    colour;
      logic [1:0] flow;
   } verdict_s;
endpackage : meter_pkg

// ### sim/mac_tx.sv
// ****************************************************************
// Subscriber MAC model: sends DA..FCS bytes, one byte a cycle
// ****************************************************************
module mac_tx
   import meter_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       go,
   input  wire logic [7:0] len,
   input  wire logic [1:0] flow,
   input  wire logic       ftype,
   input  wire logic [7:0] gap,
   output rx_s             rx,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int idle = 255;
   // Idle slots carry junk qualifiers so the meter cannot lean on them
   task automatic idle_slot();
      rx <= '{1'b0, 1'b0, 2'($urandom), 1'($urandom)};
   endtask : idle_slot
   // Start values before the first edge
   initial begin
      rx   = '0;
      busy = 1'b0;
   end
   // One frame per go; a short gap only when the bench asks for one
   always begin
      @(posedge clk_sys);
      if (go) begin
         busy <= 1'b1;
         while (idle < gap) begin
            idle_slot();
            idle++;
            @(posedge clk_sys);
         end
         // No preamble, delimiter or extension bytes on this port
         for (int i = 0; i < len; i++) begin
            rx <= '{1'b1, i == len - 1, flow, ftype};
            @(posedge clk_sys);
         end
         busy <= 1'b0;
         idle_slot();
         idle = 1;
      end else begin
         idle_slot();
         if (idle < 255) idle++;
      end
   end
endmodule : mac_tx

// ### sim/tb.sv
`include "meter_defs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
   fail_count++; $display("[ERR] %0t got %h exp %h", $time, got, exp); \
   end end
// ****************************************************************
// Meter bench: register port tasks, frame sender, scoreboard
// ****************************************************************
module tb
   import meter_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk_sys = 1'b0;
   logic              reset_n = 1'b0;
   logic [`ADDR_W-1:0] reg_addr = '0;
   logic [31:0]       reg_wdata = '0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [31:0]       reg_rdata;
   rx_s               rx;
   verdict_s          verdict;
   logic              go = 1'b0;
   logic [7:0]        len = '0;
   logic [1:0]        fl = '0;
   logic              ft = 1'b0;
   logic [7:0]        gap = 8'h14;
   logic              busy;
   logic              rd_seen = 1'b0;
   logic [31:0]       e_rd;
   verdict_s          e_vd;
   logic [31:0]       rd_q[$];
   verdict_s          vd_q[$];
   int                fail_count = 0;
   int                comparisons = 0;
   int                cycles = 0;
   localparam logic [1:0] G = `GLB_BASE;

   always #4 clk_sys = ~clk_sys;

   envelope_token_bucket_meter u_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx(rx), .verdict(verdict));
   mac_tx u_mac (
      .clk_sys(clk_sys), .go(go), .len(len), .flow(fl), .ftype(ft),
      .gap(gap), .rx(rx), .busy(busy));

   function automatic logic [5:0] ad(input logic [1:0] f,
                                     input logic [3:0] fld);
      return {f, fld};
   endfunction : ad
   // Legal spacing with some spread above the minimum
   function automatic logic [7:0] rgap();
      return 8'(`PKT_GAP_BYTES + $urandom_range(7));
   endfunction : rgap
   // Strobe tasks start just after an edge and leave one edge behind
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask : rd
   task automatic send(input logic [7:0] l, input logic [1:0] f,
                       input logic t, input logic [7:0] g,
                       input colour_e c);
      vd_q.push_back('{1'b1, c, f});
      len <= l;
      fl  <= f;
      ft  <= t;
      gap <= g;
      go  <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (400) begin
         @(posedge clk_sys);
         if (busy === 1'b0) break;
      end
   endtask : send
   task automatic final_report();
      fail_count += rd_q.size() + vd_q.size();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   // Outputs are looked at mid-cycle, once the edge has settled
   always @(posedge clk_sys) rd_seen <= reg_rd;
   always @(negedge clk_sys) begin
      if (rd_seen) begin
         e_rd = rd_q.size() ? rd_q.pop_front() : 'x;
         `CHK(reg_rdata, e_rd)
      end
      if (verdict.valid !== 1'b0) begin
         e_vd = vd_q.size() ? vd_q.pop_front() : 'x;
         `CHK(verdict, e_vd)
      end
   end
   // Hang guard, well above the thousand or so cycles the run needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("[ERR] %0t timeout", $time);
         final_report();
      end
   end

   initial begin
      void'($urandom(32'h4c50d8be));
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      // Reset state and an unmapped field
      rd(ad(G, `GLB_INTERVAL), 32'h0000007d);
      rd(ad(G, `GLB_ENVTYPE), 32'h0);
      rd(ad(G, `GLB_STATUS), 32'h0);
      rd(ad(2'h2, `FLD_CCOUNT), 32'h0);
      rd(ad(2'h0, 4'h9), 32'h0);
      $display("reset test done");
      // Fast refill; flow 2 coupled, flow 0 fully capped
      wr(ad(G, `GLB_INTERVAL), 32'h3);
      wr(ad(2'h2, `FLD_CBS), 32'd64);
      wr(ad(2'h2, `FLD_EBS), 32'd40);
      wr(ad(2'h2, `FLD_CCAP), 32'd8);
      wr(ad(2'h2, `FLD_ECAP), 32'd8);
      wr(ad(2'h2, `FLD_CF), 32'h1);
      wr(ad(2'h1, `FLD_EBS), 32'd24);
      wr(ad(2'h1, `FLD_ECAP), 32'd8);
      wr(ad(2'h0, `FLD_CBS), 32'd100);
      wr(ad(2'h0, `FLD_ECAP), 32'd16);
      wr(ad(2'h0, `FLD_CRATE), 32'd16);
      wr(ad(2'h2, `FLD_CRATE), 32'd8);
      rd(ad(2'h2, `FLD_CBS), 32'd64);
      repeat (300) @(posedge clk_sys);
      rd(ad(2'h2, `FLD_CCOUNT), 32'd64);
      rd(ad(2'h2, `FLD_ECOUNT), 32'd40);
      rd(ad(2'h1, `FLD_ECOUNT), 32'd24);
      rd(ad(2'h1, `FLD_CCOUNT), 32'd0);
      rd(ad(2'h0, `FLD_CCOUNT), 32'd0);
      rd(ad(2'h0, `FLD_ECOUNT), 32'd0);
      wr(ad(2'h2, `FLD_CRATE), 32'd0);
      $display("fill test done");
      // Colour choice and deduction, frames on legal gaps
      send(8'd60, 2'h2, 1'b0, rgap(), COL_GREEN);
      rd(ad(2'h2, `FLD_CCOUNT), 32'd4);
      send(8'd30, 2'h2, 1'b0, rgap(), COL_YELLOW);
      rd(ad(2'h2, `FLD_ECOUNT), 32'd10);
      send(8'd30, 2'h2, 1'b0, rgap(), COL_RED);
      send(8'd4, 2'h2, 1'b1, rgap(), COL_RED);
      rd(ad(2'h2, `FLD_CCOUNT), 32'd4);
      rd(ad(2'h2, `FLD_ECOUNT), 32'd10);
      send(8'd24, 2'h1, 1'b0, rgap(), COL_YELLOW);
      rd(ad(2'h1, `FLD_ECOUNT), 32'd0);
      send(8'd1, 2'h0, 1'b0, rgap(), COL_RED);
      send(8'd8, 2'h3, 1'b0, rgap(), COL_RED);
      wr(ad(2'h2, `FLD_CCOUNT), 32'd99);
      rd(ad(2'h2, `FLD_CCOUNT), 32'd4);
      $display("colour test done");
      // Uncoupled cascade down to flow 0, then the flow type switch
      wr(ad(2'h2, `FLD_CF), 32'h0);
      wr(ad(2'h2, `FLD_CBS), 32'd4);
      wr(ad(2'h0, `FLD_CCAP), 32'd32);
      wr(ad(2'h1, `FLD_ERATE), 32'd4);
      wr(ad(2'h2, `FLD_CRATE), 32'd8);
      repeat (60) @(posedge clk_sys);
      rd(ad(2'h0, `FLD_CCOUNT), 32'd100);
      rd(ad(2'h2, `FLD_ECOUNT), 32'd10);
      rd(ad(2'h1, `FLD_CCOUNT), 32'd0);
      rd(ad(2'h1, `FLD_ECOUNT), 32'd24);
      wr(ad(2'h2, `FLD_CRATE), 32'd0);
      wr(ad(2'h0, `FLD_CRATE), 32'd0);
      wr(ad(G, `GLB_ENVTYPE), 32'h1);
      rd(ad(G, `GLB_ENVTYPE), 32'h1);
      send(8'd4, 2'h0, 1'b0, rgap(), COL_RED);
      send(8'd60, 2'h0, 1'b1, rgap(), COL_GREEN);
      rd(ad(2'h0, `FLD_CCOUNT), 32'd40);
      $display("cascade test done");
      // Spacing check: legal gap, then a short one, then clear
      send(8'd8, 2'h3, 1'b0, 8'd20, COL_RED);
      rd(ad(G, `GLB_STATUS), 32'h0);
      send(8'd8, 2'h3, 1'b0, 8'd5, COL_RED);
      rd(ad(G, `GLB_STATUS), 32'h1);
      wr(ad(G, `GLB_STATUS), 32'h0);
      rd(ad(G, `GLB_STATUS), 32'h0);
      $display("gap test done");
      // Rate measurement over two frames 30 byte times apart
      wr(ad(G, `GLB_MBITS), 32'h0);
      send(8'd10, 2'h3, 1'b0, 8'd20, COL_RED);
      send(8'd12, 2'h3, 1'b0, 8'd30, COL_RED);
      rd(ad(G, `GLB_MBITS), 32'd22 * `BYTE_BITS);
      rd(ad(G, `GLB_MTIME), 32'd52 * `BYTE_BITS + `OVH_BITS);
      $display("measure test done");
      repeat (4) @(posedge clk_sys);
      final_report();
   end
endmodule : tb
